// file: ars_pkg.sv
// constants and types shared by the converter register access block
package ars_pkg;
  // fixed slave address base; bit 0 comes from the factory variant
  localparam logic [6:0] ADDR_BASE = 7'h48;
  localparam logic [7:0] GC_ADDR = 8'h00;
  localparam logic [7:0] GC_RESET_DATA = 8'h06;
  localparam logic [7:0] GC_ALT_DATA = 8'h04;
  // configuration register layout and reset values
  localparam logic [7:0] CFG_RESET = 8'h80;
  localparam int CFG_START_BIT = 7;
  localparam int CFG_ONE_SHOT_BIT = 4;
  localparam int CFG_GAIN_LSB = 0;
  localparam logic CFG_ONE_SHOT_RESET = 1'h0;
  localparam logic [1:0] CFG_GAIN_RESET = 2'h0;
  localparam logic CONV_ACTIVE_RESET = 1'h1;
  localparam logic [15:0] RESULT_RESET = 16'h0000;
  // read byte sequence
  localparam logic [1:0] RD_RESULT_HI = 2'h0;
  localparam logic [1:0] RD_RESULT_LO = 2'h1;
  localparam logic [1:0] RD_CONFIG = 2'h2;
  localparam logic [1:0] RD_FILL = 2'h3;
  localparam logic [7:0] FILL_BYTE = 8'hff;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  // serial bit engine states
  typedef enum logic [2:0] {
    LK_IDLE = 3'h0,
    LK_RX = 3'h1,
    LK_RACK = 3'h3,
    LK_RSLOT = 3'h2,
    LK_TX = 3'h6,
    LK_TACK = 3'h7
  } ars_link_st_t;
  // transaction states
  typedef enum logic [2:0] {
    TS_IDLE = 3'h0,
    TS_ADDR = 3'h1,
    TS_WFIRST = 3'h3,
    TS_WREST = 3'h2,
    TS_READ = 3'h6,
    TS_GCALL = 3'h7,
    TS_SKIP = 3'h5
  } ars_txn_st_t;
endpackage : ars_pkg

// file: ars_link_if.sv
// byte-level carrier between the serial bit engine and the register bank
`timescale 1ns/100ps
interface ars_link_if;
  logic start;
  logic stop;
  logic rx_valid;
  logic [7:0] rx_data;
  logic ack;
  logic go_tx;
  logic tx_next;
  logic [7:0] tx_data;
  modport link (output start, output stop, output rx_valid, output rx_data, output tx_next,
                input ack, input go_tx, input tx_data);
  modport regs (input start, input stop, input rx_valid, input rx_data, input tx_next,
                output ack, output go_tx, output tx_data);
endinterface : ars_link_if

// file: ars_bit_link.sv
// serial two-wire slave bit engine: start/stop detect, byte shift, ack slots
`timescale 1ns/100ps
module ars_bit_link (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  ars_link_if.link lk
);
  ars_pkg::ars_link_st_t st_ff;
  logic scl_q_ff;
  logic sda_q_ff;
  logic [3:0] cnt_ff;
  logic [7:0] shift_ff;
  logic ack_ff;
  logic read_ff;
  logic oe_ff;
  logic scl_rise;
  logic scl_fall;
  logic load_now;

  // previous line levels for edge and condition detection
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      scl_q_ff <= 1'b1;
      sda_q_ff <= 1'b1;
    end else begin
      scl_q_ff <= scl_i;
      sda_q_ff <= sda_i;
    end
  end

  // bus events and byte handshakes
  assign scl_rise = scl_i & ~scl_q_ff;
  assign scl_fall = ~scl_i & scl_q_ff;
  assign lk.start = scl_i & scl_q_ff & sda_q_ff & ~sda_i;
  assign lk.stop = scl_i & scl_q_ff & ~sda_q_ff & sda_i;
  assign lk.rx_data = {shift_ff[6:0], sda_i};
  assign lk.rx_valid = (st_ff == ars_pkg::LK_RX) & scl_rise & (cnt_ff == 4'h7);
  assign load_now = scl_fall & (((st_ff == ars_pkg::LK_RSLOT) & ack_ff & read_ff) |
                                ((st_ff == ars_pkg::LK_TX) & (cnt_ff == 4'h0)));
  assign lk.tx_next = load_now;
  assign sda_o = 1'b0; // open drain: only ever pulls low
  assign sda_oe_o = oe_ff;

  // bit sequencing; bytes go out most significant bit first
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_ff <= ars_pkg::LK_IDLE;
      cnt_ff <= 4'h0;
      shift_ff <= 8'h00;
      ack_ff <= 1'b0;
      read_ff <= 1'b0;
      oe_ff <= 1'b0;
    end else if (lk.start) begin
      st_ff <= ars_pkg::LK_RX;
      cnt_ff <= 4'h0;
      oe_ff <= 1'b0;
    end else if (lk.stop) begin
      st_ff <= ars_pkg::LK_IDLE;
      oe_ff <= 1'b0;
    end else if (load_now) begin
      st_ff <= ars_pkg::LK_TX;
      cnt_ff <= 4'h0;
      shift_ff <= lk.tx_data;
      oe_ff <= ~lk.tx_data[7]; // [RQ16]
    end else begin
      case (st_ff)
        ars_pkg::LK_RX: begin
          if (scl_rise) begin
            shift_ff <= lk.rx_data;
            cnt_ff <= cnt_ff + 4'h1;
            if (cnt_ff == 4'h7) begin
              ack_ff <= lk.ack;
              read_ff <= lk.go_tx;
              st_ff <= ars_pkg::LK_RACK;
            end
          end
        end
        ars_pkg::LK_RACK: begin
          if (scl_fall) begin
            oe_ff <= ack_ff;
            st_ff <= ars_pkg::LK_RSLOT;
          end
        end
        ars_pkg::LK_RSLOT: begin
          if (scl_fall) begin
            oe_ff <= 1'b0;
            cnt_ff <= 4'h0;
            st_ff <= ack_ff ? ars_pkg::LK_RX : ars_pkg::LK_IDLE; // unacked bytes end the transfer
          end
        end
        ars_pkg::LK_TX: begin
          if (scl_rise) begin
            cnt_ff <= cnt_ff + 4'h1;
          end else if (scl_fall && cnt_ff == ars_pkg::BITS_PER_BYTE) begin
            oe_ff <= 1'b0; // master owns the ack slot
            st_ff <= ars_pkg::LK_TACK;
          end else if (scl_fall) begin
            shift_ff <= {shift_ff[6:0], 1'b0};
            oe_ff <= ~shift_ff[6]; // [RQ16]
          end
        end
        ars_pkg::LK_TACK: begin
          if (scl_rise) begin
            cnt_ff <= 4'h0;
            st_ff <= sda_i ? ars_pkg::LK_IDLE : ars_pkg::LK_TX; // [RQ11]
          end
        end
        default: begin
          st_ff <= ars_pkg::LK_IDLE;
        end
      endcase
    end
  end
endmodule : ars_bit_link

// file: ars_adc_regs.sv
// register access block of a 12-bit converter behind a two-wire serial slave port
// Contract
// [RQ1] result is 12-bit code sign-extended to 16
// [RQ2] result reads zero until first conversion done
// [RQ3] configuration register is 8 bits, resets 80h
// [RQ4] one-shot: writing start bit one starts conversion
// [RQ5] continuous mode ignores written start bit
// [RQ6] one-shot read: busy one, idle zero
// [RQ7] continuous mode reads start bit as one
// [RQ8] bit 4 selects one-shot, resets zero
// [RQ9] bits 1:0 select gain 1,2,4,8
// [RQ10] read returns result bytes, then configuration
// [RQ11] master may stop reading after two bytes
// [RQ12] fourth and later read bytes are FFh
// [RQ13] first written data byte goes to configuration
// [RQ14] only first write byte acked and used
// [RQ15] result register not writable over bus
// [RQ16] result high byte first, bits MSB first
// [RQ17] one-shot done: load result, clear busy
// [RQ18] general call 00h then 06h resets all
// [RQ19] fixed 7-bit address, variant picks lsb
`timescale 1ns/100ps
module ars_adc_regs #(
  parameter logic ADDR_VARIANT = 1'b0
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic conv_done_i,
  input wire logic [11:0] conv_code_i,
  output logic conv_run_o,
  output logic conv_start_o,
  output logic conv_abort_o,
  output logic one_shot_select_o,
  output logic [1:0] gain_o,
  output logic [15:0] result_o
);
  ars_link_if lk ();
  ars_pkg::ars_txn_st_t txn_ff;
  ars_pkg::ars_txn_st_t nxt_txn;
  logic [15:0] result_ff;
  logic [7:0] result_lo_hold_ff;
  logic one_shot_select_ff;
  logic gain_select_hi_ff;
  logic gain_select_lo_ff;
  logic conv_active_ff;
  logic conv_start_ff;
  logic conv_abort_ff;
  logic [1:0] rd_idx_ff;
  logic [6:0] own_addr;
  logic start_busy_flag;
  logic [7:0] cfg_read;
  logic wr_cfg;
  logic gc_rst;
  logic start_req;
  logic new_one_shot;

  // serial bit engine
  ars_bit_link u_link (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .sda_o(sda_o),
    .sda_oe_o(sda_oe_o),
    .lk(lk.link)
  );

  // own address and the events a received byte triggers
  assign own_addr = ars_pkg::ADDR_BASE | {6'h00, ADDR_VARIANT}; // [RQ19]
  assign wr_cfg = lk.rx_valid & (txn_ff == ars_pkg::TS_WFIRST); // [RQ13] [RQ14]
  assign gc_rst = lk.rx_valid & (txn_ff == ars_pkg::TS_GCALL) & (lk.rx_data == ars_pkg::GC_RESET_DATA); // [RQ18]
  assign new_one_shot = wr_cfg ? lk.rx_data[ars_pkg::CFG_ONE_SHOT_BIT] : one_shot_select_ff;
  assign start_req = wr_cfg & lk.rx_data[ars_pkg::CFG_ONE_SHOT_BIT] &
                     lk.rx_data[ars_pkg::CFG_START_BIT] & ~conv_active_ff; // [RQ4] [RQ5]

  // start/busy as read back: live busy in one-shot, always one in continuous
  assign start_busy_flag = one_shot_select_ff ? conv_active_ff : 1'b1; // [RQ6] [RQ7]
  assign cfg_read = {start_busy_flag, 2'b00, one_shot_select_ff, 2'b00,
                     gain_select_hi_ff, gain_select_lo_ff};

  // transaction tracking: address byte, first data byte, the rest
  always_comb begin
    nxt_txn = txn_ff;
    lk.ack = 1'b0;
    lk.go_tx = 1'b0;
    if (lk.start) begin
      nxt_txn = ars_pkg::TS_ADDR;
    end else if (lk.stop) begin
      nxt_txn = ars_pkg::TS_IDLE;
    end else if (lk.rx_valid) begin
      case (txn_ff)
        ars_pkg::TS_ADDR: begin
          if (lk.rx_data[7:1] == own_addr) begin // [RQ19]
            lk.ack = 1'b1;
            lk.go_tx = lk.rx_data[0];
            nxt_txn = lk.rx_data[0] ? ars_pkg::TS_READ : ars_pkg::TS_WFIRST;
          end else if (lk.rx_data == ars_pkg::GC_ADDR) begin
            lk.ack = 1'b1; // [RQ18]
            nxt_txn = ars_pkg::TS_GCALL;
          end else begin
            nxt_txn = ars_pkg::TS_SKIP;
          end
        end
        ars_pkg::TS_WFIRST: begin
          lk.ack = 1'b1; // [RQ13]
          nxt_txn = ars_pkg::TS_WREST;
        end
        ars_pkg::TS_GCALL: begin
          lk.ack = (lk.rx_data == ars_pkg::GC_RESET_DATA) | (lk.rx_data == ars_pkg::GC_ALT_DATA); // [RQ18]
          nxt_txn = ars_pkg::TS_SKIP;
        end
        ars_pkg::TS_WREST: begin
          lk.ack = 1'b0; // [RQ14]
        end
        default: begin
          lk.ack = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      txn_ff <= ars_pkg::TS_IDLE;
    end else begin
      txn_ff <= nxt_txn;
    end
  end

  // configuration register: only the first write byte lands here
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      one_shot_select_ff <= ars_pkg::CFG_ONE_SHOT_RESET; // [RQ3] [RQ8]
      gain_select_hi_ff <= ars_pkg::CFG_GAIN_RESET[1]; // [RQ9]
      gain_select_lo_ff <= ars_pkg::CFG_GAIN_RESET[0];
    end else if (gc_rst) begin
      one_shot_select_ff <= ars_pkg::CFG_ONE_SHOT_RESET; // [RQ18]
      gain_select_hi_ff <= ars_pkg::CFG_GAIN_RESET[1];
      gain_select_lo_ff <= ars_pkg::CFG_GAIN_RESET[0];
    end else if (wr_cfg) begin
      one_shot_select_ff <= lk.rx_data[ars_pkg::CFG_ONE_SHOT_BIT]; // [RQ8]
      gain_select_hi_ff <= lk.rx_data[ars_pkg::CFG_GAIN_LSB + 1]; // [RQ9]
      gain_select_lo_ff <= lk.rx_data[ars_pkg::CFG_GAIN_LSB];
    end
  end

  // conversion activity; a switch to continuous mode in the done cycle keeps it busy
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      conv_active_ff <= ars_pkg::CONV_ACTIVE_RESET; // [RQ3]
    end else if (gc_rst) begin
      conv_active_ff <= ars_pkg::CONV_ACTIVE_RESET; // [RQ18]
    end else if (start_req || (wr_cfg && !new_one_shot)) begin
      conv_active_ff <= 1'b1; // [RQ4]
    end else if (conv_done_i && new_one_shot) begin
      conv_active_ff <= 1'b0; // [RQ17]
    end
  end

  // one-cycle requests to the converter core
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      conv_start_ff <= 1'b0;
      conv_abort_ff <= 1'b0;
    end else begin
      conv_start_ff <= start_req; // [RQ4]
      conv_abort_ff <= gc_rst; // [RQ18]
    end
  end

  // result register: loaded only by the converter, cleared by a general call reset, never written by the bus
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      result_ff <= ars_pkg::RESULT_RESET; // [RQ2]
    end else if (gc_rst) begin
      result_ff <= ars_pkg::RESULT_RESET; // [RQ18]
    end else if (conv_done_i) begin
      result_ff <= {{4{conv_code_i[11]}}, conv_code_i}; // [RQ1] [RQ17] [RQ15]
    end
  end

  // read byte index; low byte is held when the high byte leaves
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rd_idx_ff <= ars_pkg::RD_RESULT_HI;
      result_lo_hold_ff <= 8'h00;
    end else if (lk.start) begin
      rd_idx_ff <= ars_pkg::RD_RESULT_HI;
    end else if (lk.tx_next) begin
      if (rd_idx_ff == ars_pkg::RD_RESULT_HI) begin
        result_lo_hold_ff <= result_ff[7:0];
      end
      if (rd_idx_ff != ars_pkg::RD_FILL) begin
        rd_idx_ff <= rd_idx_ff + 2'h1; // [RQ12]
      end
    end
  end

  // byte offered to the bit engine at each load
  always_comb begin
    case (rd_idx_ff)
      ars_pkg::RD_RESULT_HI: lk.tx_data = result_ff[15:8]; // [RQ10] [RQ16]
      ars_pkg::RD_RESULT_LO: lk.tx_data = result_lo_hold_ff;
      ars_pkg::RD_CONFIG: lk.tx_data = cfg_read; // [RQ10]
      default: lk.tx_data = ars_pkg::FILL_BYTE; // [RQ12]
    endcase
  end

  // outputs to the converter core
  assign conv_run_o = conv_active_ff;
  assign conv_start_o = conv_start_ff;
  assign conv_abort_o = conv_abort_ff;
  assign one_shot_select_o = one_shot_select_ff;
  assign gain_o = {gain_select_hi_ff, gain_select_lo_ff};
  assign result_o = result_ff;
endmodule : ars_adc_regs

// file: ars_adc_regs_monitor.sv
// assertion checker on the converter register block ports
`timescale 1ns/100ps
module ars_adc_regs_monitor (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic scl_i,
  input wire logic sda_oe_o,
  input wire logic conv_done_i,
  input wire logic [11:0] conv_code_i,
  input wire logic conv_run_o,
  input wire logic conv_start_o,
  input wire logic conv_abort_o,
  input wire logic one_shot_select_o,
  input wire logic [1:0] gain_o,
  input wire logic [15:0] result_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  // start pulse lasts one cycle and powers the converter
  start_pulse_a: assert property (conv_start_o |=> !conv_start_o && conv_run_o)
    else $error("start pulse too long or converter not running");
  start_mode_a: assert property (conv_start_o |=> one_shot_select_o)
    else $error("start pulse outside one-shot mode");
  cont_busy_a: assert property (!one_shot_select_o [*2] |-> conv_run_o)
    else $error("continuous mode not busy");
  // finished conversion lands sign extended in the result
  // a general call reset in the done cycle wins over the load
  done_load_a: assert property (conv_done_i |=> conv_abort_o ||
    result_o == {{4{$past(conv_code_i[11])}}, $past(conv_code_i)})
    else $error("result not loaded from code");
  // a switch to continuous mode in the done cycle keeps the converter running
  done_idle_a: assert property (conv_done_i && one_shot_select_o && !conv_start_o |=>
    !conv_run_o || conv_abort_o || !one_shot_select_o)
    else $error("one-shot busy not cleared at done");
  result_hold_a: assert property ($changed(result_o) |->
    $past(conv_done_i) || conv_abort_o || $past(conv_abort_o))
    else $error("result changed without conversion");
  gcall_clear_a: assert property (conv_abort_o |-> ##[0:1]
    (result_o == 16'h0000 && gain_o == 2'h0 && conv_run_o && !one_shot_select_o))
    else $error("general call did not restore defaults");
  // data line moves only while the bus clock is low
  sda_change_a: assert property ($changed(sda_oe_o) |-> !scl_i)
    else $error("data line changed with clock high");
endmodule : ars_adc_regs_monitor

bind ars_adc_regs ars_adc_regs_monitor u_mon (.clk_i(clk_i), .nrst_i(nrst_i), .scl_i(scl_i), .sda_oe_o(sda_oe_o),
  .conv_done_i(conv_done_i), .conv_code_i(conv_code_i), .conv_run_o(conv_run_o), .conv_start_o(conv_start_o),
  .conv_abort_o(conv_abort_o), .one_shot_select_o(one_shot_select_o), .gain_o(gain_o), .result_o(result_o));

// file: ars_bus_master.sv
// two-wire bus master model with bit and byte tasks
`timescale 1ns/100ps
module ars_bus_master (
  input wire logic clk_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_low_o
);
  // bus idles high
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask : tick
  task automatic put_bit(input logic b);
    sda_low_o <= !b;
    tick(3);
    scl_o <= 1'b1;
    tick(4);
    scl_o <= 1'b0;
    tick(3);
  endtask : put_bit
  task automatic get_bit(output logic b);
    sda_low_o <= 1'b0;
    tick(3);
    scl_o <= 1'b1;
    tick(2);
    b = sda_i;
    tick(2);
    scl_o <= 1'b0;
    tick(3);
  endtask : get_bit
  task automatic start();
    sda_low_o <= 1'b0;
    scl_o <= 1'b1;
    tick(4);
    sda_low_o <= 1'b1;
    tick(4);
    scl_o <= 1'b0;
    tick(3);
  endtask : start
  task automatic stop();
    sda_low_o <= 1'b1;
    tick(3);
    scl_o <= 1'b1;
    tick(4);
    sda_low_o <= 1'b0;
    tick(4);
  endtask : stop
  task automatic put_byte(input logic [7:0] d, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) put_bit(d[i]);
    get_bit(b);
    ack = !b;
  endtask : put_byte
  // last byte is refused so the slave lets go of the line
  task automatic get_byte(output logic [7:0] d, input logic last);
    for (int i = 7; i >= 0; i--) get_bit(d[i]);
    put_bit(last);
  endtask : get_byte
endmodule : ars_bus_master

// file: ars_adc_regs_tb_top.sv
// self-checking bench for the converter register block
`timescale 1ns/100ps
module ars_adc_regs_tb_top;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic conv_done_i = 1'b0;
  logic [11:0] conv_code_i = 12'h000;
  logic scl, sda_low, sda, sda_o, sda_oe_o, conv_run_o, conv_start_o, conv_abort_o, one_shot_select_o, k;
  logic [1:0] gain_o;
  logic [15:0] result_o;
  int miscompares = 0;
  int checks = 0;
  int starts = 0;
  int aborts = 0;
  always #20 clk_i = ~clk_i;
  // count the one-cycle requests to the converter core
  always @(posedge clk_i) begin
    if (conv_start_o === 1'b1) starts++;
    if (conv_abort_o === 1'b1) aborts++;
  end
  // open-drain data wire with pull-up
  assign sda = !(sda_low || sda_oe_o);
  ars_bus_master u_mst (.clk_i(clk_i), .sda_i(sda), .scl_o(scl), .sda_low_o(sda_low));
  ars_adc_regs #(.ADDR_VARIANT(1'b1)) u_dut (.clk_i(clk_i), .nrst_i(nrst_i), .scl_i(scl), .sda_i(sda),
    .sda_o(sda_o), .sda_oe_o(sda_oe_o), .conv_done_i(conv_done_i), .conv_code_i(conv_code_i),
    .conv_run_o(conv_run_o), .conv_start_o(conv_start_o), .conv_abort_o(conv_abort_o),
    .one_shot_select_o(one_shot_select_o), .gain_o(gain_o), .result_o(result_o));
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic close_out();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : close_out
  // write one or two data bytes to the configuration
  task automatic wr(input logic [7:0] d, input logic two);
    u_mst.start();
    u_mst.put_byte(8'h92, k);
    chk("write address ack", 16'(k), 16'h0001);
    u_mst.put_byte(d, k);
    chk("first data ack", 16'(k), 16'h0001);
    if (two) begin
      u_mst.put_byte(8'h00, k);
      chk("second data ack", 16'(k), 16'h0000);
    end
    u_mst.stop();
  endtask : wr
  // read n bytes and compare against packed expectation
  task automatic rd(input int n, input logic [31:0] e);
    logic [7:0] d;
    u_mst.start();
    u_mst.put_byte(8'h93, k);
    chk("read address ack", 16'(k), 16'h0001);
    for (int i = 0; i < n; i++) begin
      u_mst.get_byte(d, 1'(i == n - 1));
      chk("read byte", 16'(d), 16'(e[31 - 8 * i -: 8]));
    end
    u_mst.stop();
  endtask : rd
  task automatic cnv(input logic [11:0] code);
    conv_done_i <= 1'b1;
    conv_code_i <= code;
    @(posedge clk_i);
    conv_done_i <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask : cnv
  // general call address followed by one data byte
  task automatic gcall(input logic [7:0] d, input logic acked);
    u_mst.start();
    u_mst.put_byte(8'h00, k);
    chk("general call address ack", 16'(k), 16'h0001);
    u_mst.put_byte(d, k);
    chk("general call data ack", 16'(k), 16'(acked));
    u_mst.stop();
  endtask : gcall
  // cut a hang short
  initial begin
    repeat (50000) @(posedge clk_i);
    miscompares++;
    close_out();
  end
  // main sequence
  initial begin
    repeat (16) @(posedge clk_i);
    nrst_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    rd(3, 32'h0000_80ff);
    $display("test reset values done");
    wr(8'h13, 1'b0);
    chk("one-shot select", 16'(one_shot_select_o), 16'h0001);
    cnv(12'ha05);
    chk("idle after done", 16'(conv_run_o), 16'h0000);
    chk("result port", result_o, 16'hfa05);
    chk("data line drive level", 16'(sda_o), 16'h0000);
    rd(4, 32'hfa05_13ff);
    wr(8'h13, 1'b0);
    chk("zero start bit", 16'(conv_run_o), 16'h0000);
    wr(8'h93, 1'b1);
    chk("started", 16'(conv_run_o), 16'h0001);
    chk("start pulses", 16'(starts), 16'h0001);
    rd(3, 32'hfa05_9300);
    cnv(12'h123);
    rd(2, 32'h0123_0000);
    $display("test one-shot done");
    for (int g = 0; g < 4; g++) begin
      wr({g[0], 5'h00, g[1:0]}, 1'b0);
      chk("gain", 16'(gain_o), 16'(g));
      rd(3, {16'h0123, 8'h80 | 8'(g), 8'h00});
    end
    chk("no start in continuous", 16'(starts), 16'h0001);
    $display("test gain and continuous done");
    u_mst.start();
    u_mst.put_byte(8'h90, k);
    chk("other address nack", 16'(k), 16'h0000);
    u_mst.stop();
    gcall(8'h04, 1'b1);
    gcall(8'h05, 1'b0);
    chk("gain kept", 16'(gain_o), 16'h0003);
    chk("no abort yet", 16'(aborts), 16'h0000);
    u_mst.start();
    u_mst.put_byte(8'h00, k);
    chk("general call ack", 16'(k), 16'h0001);
    u_mst.put_byte(8'h06, k);
    chk("reset data ack", 16'(k), 16'h0001);
    u_mst.stop();
    chk("gain after reset", 16'(gain_o), 16'h0000);
    rd(3, 32'h0000_8000);
    chk("abort pulses", 16'(aborts), 16'h0001);
    chk("result port cleared", result_o, 16'h0000);
    chk("continuous after reset", 16'(one_shot_select_o), 16'h0000);
    $display("test address and general call done");
    close_out();
  end
endmodule : ars_adc_regs_tb_top
